// File: tb/oprc_keypad.sv
// Front panel keypad model pressed by the operator
`timescale 1ns/1ps
`default_nettype none
module oprc_keypad (
   // Clock
   input  wire logic       clk_i,
   // Keys asked for: run, am_a, am_b, up, down
   input  wire logic [4:0] press_i,
   // Key pins, high while pressed
   output logic      [4:0] key_o
);
   // Keys move just after the edge and stay as long as asked
   always_ff @(posedge clk_i) key_o <= press_i;
endmodule
`default_nettype wire

// File: tb/oprc_top_sva.sv
// Port assertions for the supervisor
`timescale 1ns/1ps
`default_nettype none
module oprc_top_sva #(
   parameter int CYC_PER_SEC = 20
) (
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic [3:0]  addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [15:0] rdata_o,
   input wire logic        key_run_i,
   input wire logic        key_am_a_i,
   input wire logic        key_am_b_i,
   input wire logic [3:0]  cur_step_i,
   input wire logic        run_o,
   input wire logic        reset_led_o,
   input wire logic        manual_o,
   input wire logic        goto_level0_o,
   input wire logic        time_count_en_o,
   input wire logic        limiter_bypass_o,
   input wire logic        tune_led_o,
   input wire logic [7:0]  mode_reachable_o,
   input wire logic        level0_in_menu_o,
   input wire logic        edit_enable_o
);
   int run_cnt, am_cnt;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Raw hold lengths of the run key and the two-key combination
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_cnt <= 0;
         am_cnt  <= 0;
      end else begin
         run_cnt <= key_run_i ? run_cnt + 1 : 0;
         am_cnt  <= (key_am_a_i && key_am_b_i) ? am_cnt + 1 : 0;
      end
   end
   property p_led; reset_led_o == !run_o; endproperty
   a_led: assert property (p_led) else $error("reset lamp wrong");
   property p_start; $rose(run_o) |-> run_cnt >= CYC_PER_SEC; endproperty
   a_start: assert property (p_start) else $error("run began early");
   property p_man; $changed(manual_o) |-> am_cnt >= CYC_PER_SEC; endproperty
   a_man: assert property (p_man) else $error("manual toggled early");
   property p_lvl0; !level0_in_menu_o |-> mode_reachable_o == 8'h01; endproperty
   a_lvl0: assert property (p_lvl0) else $error("hidden level wrong");
   property p_mon; !edit_enable_o |-> mode_reachable_o == 8'h01 && !level0_in_menu_o; endproperty
   a_mon: assert property (p_mon) else $error("monitor mode wrong");
   property p_open;
      wr_i && addr_i == oprc_pkg::ADDR_SECURITY && wdata_i == 16'h0000
      |=> mode_reachable_o == 8'hff && edit_enable_o;
   endproperty
   a_open: assert property (p_open) else $error("security zero wrong");
   property p_goto; goto_level0_o |-> !manual_o ##1 !goto_level0_o; endproperty
   a_goto: assert property (p_goto) else $error("level0 pulse wrong");
   property p_byp; limiter_bypass_o |-> !run_o && !manual_o; endproperty
   a_byp: assert property (p_byp) else $error("bypass wrong");
   property p_tcnt; time_count_en_o |-> run_o; endproperty
   a_tcnt: assert property (p_tcnt) else $error("time count wrong");
   property p_rdat; rdata_o != 16'h0000 |-> $past(rd_i); endproperty
   a_rdat: assert property (p_rdat) else $error("stray read data");
   property p_steps;
      run_o && wr_i && addr_i == oprc_pkg::ADDR_STEP_COUNT && wdata_i[15:5] == 11'h000
      && wdata_i[4:0] != 5'h00 && wdata_i[4:0] <= {1'b0, cur_step_i} |-> ##[1:2] !run_o;
   endproperty
   a_steps: assert property (p_steps) else $error("run kept");
   c_run: cover property ($rose(run_o));
   c_man: cover property ($rose(manual_o));
   c_tune: cover property (tune_led_o);
endmodule
bind oprc_top oprc_top_sva #(.CYC_PER_SEC(CYC_PER_SEC)) u_sva (.*);
`default_nettype wire

// File: tb/oprc_top_test.sv
// Self-checking bench for the supervisor
`timescale 1ns/1ps
`default_nettype none
module oprc_top_test;
   localparam int S = 20;
   localparam logic [3:0] SEC = oprc_pkg::ADDR_SECURITY, KPR = oprc_pkg::ADDR_KEY_PROT;
   localparam logic [3:0] LVL = oprc_pkg::ADDR_RST_LEVEL, CFG = oprc_pkg::ADDR_CONFIG;
   localparam logic [3:0] TUN = oprc_pkg::ADDR_TUNE_CMD;
   logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, tune_done_i = 1'b0;
   logic [3:0] addr_i = 4'h0, cur_step_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000, rdata_o;
   logic [4:0] press = 5'h00, key_o;
   logic [11:0] pid_level_i = 12'h000, output_level_o, lv;
   logic limiter_bypass_o, valve_open_o, valve_close_o, run_o, reset_led_o, manual_o;
   logic goto_level0_o, time_count_en_o, tune_led_o, tune_narrow_shown_o;
   logic level0_in_menu_o, edit_enable_o;
   logic [1:0] tune_mode_o;
   logic [7:0] mode_reachable_o;
   int err_total = 0, checks_done = 0;
   // Clock at 200 MHz
   always #2.5 clk_i = ~clk_i;
   oprc_keypad u_pad (.clk_i, .press_i(press), .key_o);
   oprc_top #(.CYC_PER_SEC(S), .CYC_PER_FLASH(10), .CYC_PER_RAMP(3)) u_dut (
      .key_run_i(key_o[4]), .key_am_a_i(key_o[3]), .key_am_b_i(key_o[2]),
      .key_up_i(key_o[1]), .key_down_i(key_o[0]), .pid_open_i(1'b0), .pid_close_i(1'b0), .*);
   // Reachable modes per security value
   function automatic logic [7:0] mask(input int s);
      return (s == 0) ? 8'hff : (s < 5) ? 8'hff >> s : 8'h01;
   endfunction
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic chk(input logic ok, input string m);
      checks_done++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input string m);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o === e, m);
      @(posedge clk_i);
   endtask
   // Hold keys n cycles, then settle
   task automatic hold(input logic [4:0] k, input int n);
      @(posedge clk_i);
      press <= k;
      repeat (n) @(posedge clk_i);
      press <= 5'h00;
      cyc(8);
   endtask
   // Cut a hang short
   initial begin
      repeat (100000) @(posedge clk_i);
      err_total++;
      close_out();
   end
   initial begin
      void'($urandom(32'h0722));
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      pid_level_i <= 12'($urandom_range(1000, 0));
      cyc(1);
      chk(mode_reachable_o === 8'h7f && reset_led_o === 1'b1, "reset outs");
      rd(SEC, 16'h0001, "security");
      rd(KPR, 16'h0000, "key prot");
      rd(4'hf, 16'h0000, "unmapped");
      for (int i = 0; i < 8; i++) begin
         wr(SEC, 16'(i));
         chk(mode_reachable_o === mask(i) && edit_enable_o === (i < 6), "modes");
         chk(level0_in_menu_o === (i < 5), "menu");
      end
      wr(SEC, 16'h0001);
      $display("test security done");
      lv = 12'($urandom_range(1049, 0));
      wr(LVL, {4'h0, lv});
      wr(LVL, 16'h041b);
      rd(LVL, {4'h0, lv}, "level kept");
      cyc(40);
      chk(output_level_o === lv && limiter_bypass_o === 1'b1, "reset level");
      hold(5'h0c, S + 6);
      chk(manual_o === 1'b1, "manual on");
      wr(LVL, 16'h0000);
      cyc(4);
      chk(output_level_o === lv, "manual wins");
      hold(5'h02, 2);
      cyc(S);
      chk(output_level_o === lv, "early change");
      cyc(2 * S);
      chk(output_level_o === lv + 12'h001, "late change");
      hold(5'h0c, S + 6);
      chk(manual_o === 1'b0, "manual off");
      $display("test manual done");
      wr(TUN, 16'h0002);
      chk(tune_mode_o === 2'h0, "tune in reset");
      hold(5'h10, S + 6);
      chk(run_o === 1'b1 && reset_led_o === 1'b0, "run");
      hold(5'h10, S + 6);
      chk(run_o === 1'b1, "short stop");
      wr(TUN, 16'h0002);
      chk(tune_mode_o === 2'h2 && time_count_en_o === 1'b0, "tuning");
      hold(5'h10, 2 * S + 6);
      chk(run_o === 1'b1, "stop while tuning");
      tune_done_i <= 1'b1;
      @(posedge clk_i);
      tune_done_i <= 1'b0;
      cyc(2);
      chk(tune_mode_o === 2'h0 && time_count_en_o === 1'b1, "tune end");
      cur_step_i <= 4'h3;
      wr(oprc_pkg::ADDR_STEP_COUNT, 16'h0003);
      cyc(2);
      chk(run_o === 1'b0 && reset_led_o === 1'b1, "step cut");
      hold(5'h10, S + 6);
      wr(CFG, 16'h0004);
      wr(TUN, 16'h0002);
      chk(tune_mode_o === 2'h0, "tune onoff");
      wr(CFG, 16'h0002);
      wr(TUN, 16'h0001);
      chk(tune_mode_o === 2'h0 && tune_narrow_shown_o === 1'b0, "narrow");
      wr(CFG, 16'h0000);
      hold(5'h10, 2 * S + 6);
      wr(CFG, 16'h0001);
      wr(oprc_pkg::ADDR_VALVE_RST, 16'h0001);
      cyc(1);
      chk(valve_open_o === 1'b1 && valve_close_o === 1'b0, "valve reset");
      wr(CFG, 16'h0000);
      $display("test tuning done");
      for (int k = 0; k < 4; k++) begin
         wr(KPR, 16'(k));
         hold(5'h10, S + 6);
         chk(run_o === !k[1], "run key");
         if (run_o === 1'b1) hold(5'h10, 2 * S + 6);
         hold(5'h0c, S + 6);
         chk(manual_o === !k[0], "am key");
         if (manual_o === 1'b1) hold(5'h0c, S + 6);
      end
      $display("test key protect done");
      close_out();
   end
endmodule
`default_nettype wire

// File: verilog/oprc_hold_if.sv
// Link between the supervisor and one key hold timer
`timescale 1ns/1ps
`default_nettype none
interface oprc_hold_if;
   logic       held;
   logic [1:0] limit;
   logic       fire;
   modport ctrl  (output held, output limit, input fire);
   modport timer (input held, input limit, output fire);
endinterface
`default_nettype wire

// File: verilog/oprc_hold_timer.sv
// Hold duration timer with a one second tick restarted on release
`timescale 1ns/1ps
`default_nettype none
module oprc_hold_timer #(
   parameter int CYC_PER_SEC = oprc_pkg::CYC_PER_SEC
) (
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   // Control side
   oprc_hold_if.timer              hold
);
   logic [oprc_pkg::PRE_W-1:0] pre_reg, pre_next;
   logic [1:0]                 secs_reg, secs_next;
   logic                       done_reg, done_next;

   // Fire once per hold when the seconds count reaches the limit
   assign hold.fire = hold.held & ~done_reg & (secs_reg >= hold.limit);

   // Tick and seconds count, cleared whenever the key is released
   always_comb begin
      pre_next  = pre_reg;
      secs_next = secs_reg;
      done_next = hold.held & (done_reg | hold.fire);
      if (!hold.held) begin
         pre_next  = '0; // R23
         secs_next = 2'h0;
      end else if (pre_reg == oprc_pkg::PRE_W'(CYC_PER_SEC - 1)) begin
         pre_next = '0;
         if (secs_reg != 2'h3) begin
            secs_next = secs_reg + 2'h1; // R23
         end
      end else begin
         pre_next = pre_reg + oprc_pkg::PRE_W'(1);
      end
   end

   // State registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pre_reg  <= '0;
         secs_reg <= 2'h0;
         done_reg <= 1'b0;
      end else begin
         pre_reg  <= pre_next;
         secs_reg <= secs_next;
         done_reg <= done_next;
      end
   end
endmodule
`default_nettype wire

// File: verilog/oprc_pkg.sv
// Shared constants for the operator protect and run control block
package oprc_pkg;
   // Clock and time base
   localparam int CLK_HZ          = 200_000_000;
   localparam int SEC_MS          = 1000;
   localparam int CYC_PER_SEC     = CLK_HZ / 1000 * SEC_MS;
   localparam int FLASH_HALF_MS   = 500;
   localparam int CYC_PER_FLASH   = CLK_HZ / 1000 * FLASH_HALF_MS;
   localparam int RAMP_STEP_MS    = 1;
   localparam int CYC_PER_RAMP    = CLK_HZ / 1000 * RAMP_STEP_MS;
   localparam int PRE_W           = 28;
   // Key hold times in seconds
   localparam logic [1:0] RUN_START_S  = 2'h1;
   localparam logic [1:0] RUN_STOP_S   = 2'h2;
   localparam logic [1:0] MAN_TOGGLE_S = 2'h1;
   localparam logic [1:0] MAN_APPLY_S  = 2'h2;
   // Register indices
   localparam logic [3:0] ADDR_SECURITY   = 4'h0;
   localparam logic [3:0] ADDR_KEY_PROT   = 4'h1;
   localparam logic [3:0] ADDR_RST_LEVEL  = 4'h2;
   localparam logic [3:0] ADDR_VALVE_RST  = 4'h3;
   localparam logic [3:0] ADDR_CONFIG     = 4'h4;
   localparam logic [3:0] ADDR_STEP_COUNT = 4'h5;
   localparam logic [3:0] ADDR_TUNE_CMD   = 4'h6;
   localparam logic [3:0] ADDR_STATUS     = 4'h7;
   localparam logic [3:0] ADDR_OUT_LEVEL  = 4'h8;
   localparam logic [3:0] ADDR_MAN_LEVEL  = 4'h9;
   // Reset values and ranges
   localparam logic [2:0]  SECURITY_RST = 3'h1;
   localparam logic [2:0]  SECURITY_MAX = 3'h6;
   localparam logic [2:0]  SEC_LVL0     = 3'h5;
   localparam logic [2:0]  SEC_MONITOR  = 3'h6;
   localparam logic [1:0]  KEY_PROT_RST = 2'h0;
   localparam logic [11:0] LEVEL_RST    = 12'h000;
   localparam logic [11:0] LEVEL_MIN    = 12'hfce;
   localparam logic [11:0] LEVEL_MAX    = 12'h41a;
   localparam logic [4:0]  STEPS_RST    = 5'h08;
   localparam logic [4:0]  STEPS_MIN    = 5'h01;
   localparam logic [4:0]  STEPS_MAX    = 5'h10;
   localparam logic [2:0]  CONFIG_RST   = 3'h0;
   // Config field positions
   localparam int CFG_VALVE    = 0;
   localparam int CFG_HEATCOOL = 1;
   localparam int CFG_ONOFF    = 2;
   // Key protect field positions
   localparam int KP_AM  = 0;
   localparam int KP_RUN = 1;
   // Valve reset mode and tuning command encodings
   typedef enum logic [1:0] {VRST_HOLD = 2'h0, VRST_OPEN = 2'h1, VRST_CLOSE = 2'h2}
      oprc_vrst_type;
   typedef enum logic [1:0] {TUNE_CANCEL = 2'h0, TUNE_NARROW = 2'h1, TUNE_FULL = 2'h2}
      oprc_tune_type;
endpackage

// File: verilog/oprc_top.sv
// Operator protect, key protect, run/reset, manual and tuning supervisor
// Functional notes
// R1 - Security 0..6, reset 1, 0 opens all
// R2 - Security 5: level 0 only, hidden
// R3 - Security 6: monitor value only, no editing
// R4 - Key protect 0 none,1 A/M,2 run,3 both
// R5 - Run key held 1 s starts run
// R6 - Run key held 2 s stops; reset lamp
// R7 - Reset requests ignored while tuning
// R8 - Reset level setting -5.0..105.0%, default 0
// R9 - Manual level kept when reset in manual
// R10 - Limiters bypassed for reset level
// R11 - Valve reset: open, close or hold
// R12 - Step count below current step ends run; code also ends it at a count equal to the current step
// R13 - Two keys 1 s toggle manual; exit level0
// R14 - Step timing advances in manual mode
// R15 - Manual level change applies after 2 s
// R16 - Bumpless ramp on auto/manual switch
// R17 - Valve manual: up opens, down closes
// R18 - Tuning refused in reset or on/off
// R19 - Tuning halts time count, flashes lamp
// R20 - Tuning command narrow/full/cancel, self clears
// R21 - Narrow tuning hidden for heat-cool, valve
// R22 - Key protect blocks selected key actions
// R23 - Hold time from restartable one second tick
`timescale 1ns/1ps
`default_nettype none
module oprc_top #(
   parameter int CYC_PER_SEC   = oprc_pkg::CYC_PER_SEC,
   parameter int CYC_PER_FLASH = oprc_pkg::CYC_PER_FLASH,
   parameter int CYC_PER_RAMP  = oprc_pkg::CYC_PER_RAMP
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Register port
   input  wire logic [3:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [15:0] rdata_o,
   // Front panel keys, asynchronous pins
   input  wire logic        key_run_i,
   input  wire logic        key_am_a_i,
   input  wire logic        key_am_b_i,
   input  wire logic        key_up_i,
   input  wire logic        key_down_i,
   // Controller core
   input  wire logic [11:0] pid_level_i,
   input  wire logic        pid_open_i,
   input  wire logic        pid_close_i,
   input  wire logic [3:0]  cur_step_i,
   input  wire logic        tune_done_i,
   // Outputs
   output logic [11:0]      output_level_o,
   output logic             limiter_bypass_o,
   output logic             valve_open_o,
   output logic             valve_close_o,
   output logic             run_o,
   output logic             reset_led_o,
   output logic             manual_o,
   output logic             goto_level0_o,
   output logic             time_count_en_o,
   output logic             tune_led_o,
   output logic [1:0]       tune_mode_o,
   output logic             tune_narrow_shown_o,
   output logic [7:0]       mode_reachable_o,
   output logic             level0_in_menu_o,
   output logic             edit_enable_o
);
   localparam int FL_W = 27;
   localparam int RP_W = 18;

   // Synchronisers for the five keys
   logic [4:0] key_s1_reg, key_s2_reg, key_d_reg;
   logic       k_run, k_am_a, k_am_b, k_up, k_down, up_edge, down_edge;

   // Registers
   logic [2:0]  security_reg, security_next;
   logic [1:0]  kprot_reg, kprot_next;
   logic [11:0] rst_level_reg, rst_level_next;
   logic [1:0]  vrst_reg, vrst_next;
   logic [2:0]  config_reg, config_next;
   logic [4:0]  steps_reg, steps_next;
   logic [1:0]  tune_reg, tune_next;
   logic [15:0] rdata_reg, rdata_next;

   // Operating state
   logic        run_reg, run_next;
   logic        man_reg, man_next;
   logic        lvl0_reg, lvl0_next;
   logic [11:0] man_level_reg, man_level_next;
   logic [11:0] pend_reg, pend_next;
   logic        pend_act_reg, pend_act_next;
   logic [11:0] out_reg, out_next;
   logic        bump_reg, bump_next;
   logic        vopen_reg, vopen_next;
   logic        vclose_reg, vclose_next;
   logic [FL_W-1:0] flash_cnt_reg, flash_cnt_next;
   logic        flash_reg, flash_next;
   logic [RP_W-1:0] ramp_cnt_reg, ramp_cnt_next;

   // Decoded helpers
   logic        am_blocked, run_blocked, tuning, ramp_tick;
   logic [11:0] target;
   logic [4:0]  wsteps;
   logic [11:0] wlevel;

   oprc_hold_if run_hold ();
   oprc_hold_if am_hold ();
   oprc_hold_if apply_hold ();

   // Key hold timers
   oprc_hold_timer #(.CYC_PER_SEC(CYC_PER_SEC)) u_run_timer (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .hold    (run_hold)
   );
   oprc_hold_timer #(.CYC_PER_SEC(CYC_PER_SEC)) u_am_timer (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .hold    (am_hold)
   );
   oprc_hold_timer #(.CYC_PER_SEC(CYC_PER_SEC)) u_apply_timer (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .hold    (apply_hold)
   );
   // Key decode from the second synchroniser stage
   assign k_run     = key_s2_reg[0];
   assign k_am_a    = key_s2_reg[1];
   assign k_am_b    = key_s2_reg[2];
   assign k_up      = key_s2_reg[3];
   assign k_down    = key_s2_reg[4];
   assign up_edge   = k_up & ~key_d_reg[3];
   assign down_edge = k_down & ~key_d_reg[4];
   // Protection and mode decode
   assign am_blocked  = kprot_reg[oprc_pkg::KP_AM]; // R4
   assign run_blocked = kprot_reg[oprc_pkg::KP_RUN]; // R4
   assign tuning      = (tune_reg != oprc_pkg::TUNE_CANCEL);
   assign ramp_tick   = (ramp_cnt_reg == RP_W'(CYC_PER_RAMP - 1));
   assign wsteps      = wdata_i[4:0];
   assign wlevel      = wdata_i[11:0];

   // Hold timer requests
   assign run_hold.held   = k_run & ~run_blocked; // R22
   assign run_hold.limit  = run_reg ? oprc_pkg::RUN_STOP_S : oprc_pkg::RUN_START_S; // R5 R6
   assign am_hold.held    = k_am_a & k_am_b & ~am_blocked; // R13 R22
   assign am_hold.limit   = oprc_pkg::MAN_TOGGLE_S; // R13
   assign apply_hold.held = pend_act_reg & ~up_edge & ~down_edge; // R15
   assign apply_hold.limit = oprc_pkg::MAN_APPLY_S; // R15

   // Level the output is heading for
   assign target = man_reg ? man_level_reg : (run_reg ? pid_level_i : rst_level_reg); // R8 R9

   // Next state of registers and operating state
   always_comb begin
      security_next  = security_reg;
      kprot_next     = kprot_reg;
      rst_level_next = rst_level_reg;
      vrst_next      = vrst_reg;
      config_next    = config_reg;
      steps_next     = steps_reg;
      tune_next      = tune_reg;
      run_next       = run_reg;
      man_next       = man_reg;
      lvl0_next      = 1'b0;
      man_level_next = man_level_reg;
      pend_next      = pend_reg;
      pend_act_next  = pend_act_reg;
      bump_next      = bump_reg;
      rdata_next     = 16'h0000;
      // Software writes
      if (wr_i) begin
         unique case (addr_i)
            oprc_pkg::ADDR_SECURITY: begin
               if (wdata_i[2:0] <= oprc_pkg::SECURITY_MAX && wdata_i[15:3] == '0) begin
                  security_next = wdata_i[2:0]; // R1
               end
            end
            oprc_pkg::ADDR_KEY_PROT: kprot_next = wdata_i[1:0]; // R4
            oprc_pkg::ADDR_RST_LEVEL: begin
               if ($signed(wlevel) >= $signed(oprc_pkg::LEVEL_MIN) &&
                   $signed(wlevel) <= $signed(oprc_pkg::LEVEL_MAX)) begin
                  rst_level_next = wlevel; // R8
               end
            end
            oprc_pkg::ADDR_VALVE_RST: if (wdata_i[1:0] != 2'h3) vrst_next = wdata_i[1:0]; // R11
            oprc_pkg::ADDR_CONFIG: config_next = wdata_i[2:0];
            oprc_pkg::ADDR_STEP_COUNT: begin
               if (wsteps >= oprc_pkg::STEPS_MIN && wsteps <= oprc_pkg::STEPS_MAX) begin
                  steps_next = wsteps;
                  if (run_reg && wsteps <= {1'b0, cur_step_i}) run_next = 1'b0; // R12
               end
            end
            oprc_pkg::ADDR_TUNE_CMD: begin
               if (wdata_i[1:0] == oprc_pkg::TUNE_CANCEL ||
                   (run_reg && !config_reg[oprc_pkg::CFG_ONOFF] && // R18
                    (wdata_i[1:0] == oprc_pkg::TUNE_FULL ||
                     (wdata_i[1:0] == oprc_pkg::TUNE_NARROW && tune_narrow_shown_o)))) begin // R21
                  tune_next = wdata_i[1:0]; // R20
               end
            end
            default: ;
         endcase
      end
      // End of tuning returns the command to cancel
      if (tune_done_i) tune_next = oprc_pkg::TUNE_CANCEL; // R20
      // Run and reset by key hold
      if (run_hold.fire && (!run_reg || !tuning)) begin // R7
         run_next = ~run_reg; // R5 R6
      end
      // Manual toggle by the two-key hold
      if (am_hold.fire) begin
         man_next  = ~man_reg; // R13
         bump_next = 1'b1; // R16
         lvl0_next = man_reg; // R13
         if (!man_reg) begin
            man_level_next = out_reg; // R16
            pend_next      = out_reg;
            pend_act_next  = 1'b0;
         end
      end else if (man_reg) begin
         // Pending manual level, applied after the keys rest
         if (up_edge && !config_reg[oprc_pkg::CFG_VALVE] &&
             $signed(pend_reg) < $signed(oprc_pkg::LEVEL_MAX)) begin
            pend_next     = pend_reg + 12'h001;
            pend_act_next = 1'b1;
         end else if (down_edge && !config_reg[oprc_pkg::CFG_VALVE] &&
                      $signed(pend_reg) > $signed(oprc_pkg::LEVEL_MIN)) begin
            pend_next     = pend_reg - 12'h001;
            pend_act_next = 1'b1;
         end else if (apply_hold.fire) begin
            man_level_next = pend_reg; // R15
            pend_act_next  = 1'b0;
         end
      end
      if (bump_reg && out_reg == target) bump_next = 1'b0;
      // Register read data, one cycle after the strobe
      if (rd_i) begin
         unique case (addr_i)
            oprc_pkg::ADDR_SECURITY:   rdata_next = {13'h0000, security_reg};
            oprc_pkg::ADDR_KEY_PROT:   rdata_next = {14'h0000, kprot_reg};
            oprc_pkg::ADDR_RST_LEVEL:  rdata_next = {4'h0, rst_level_reg};
            oprc_pkg::ADDR_VALVE_RST:  rdata_next = {14'h0000, vrst_reg};
            oprc_pkg::ADDR_CONFIG:     rdata_next = {13'h0000, config_reg};
            oprc_pkg::ADDR_STEP_COUNT: rdata_next = {11'h000, steps_reg};
            oprc_pkg::ADDR_TUNE_CMD:   rdata_next = {14'h0000, tune_reg};
            oprc_pkg::ADDR_STATUS:
               rdata_next = {11'h000, pend_act_reg, bump_reg, tuning, man_reg, run_reg};
            oprc_pkg::ADDR_OUT_LEVEL:  rdata_next = {4'h0, out_reg};
            oprc_pkg::ADDR_MAN_LEVEL:  rdata_next = {4'h0, man_level_reg};
            default:                   rdata_next = 16'h0000;
         endcase
      end
   end

   // Output level with bumpless ramp, and valve outputs
   always_comb begin
      out_next    = out_reg;
      vopen_next  = 1'b0;
      vclose_next = 1'b0;
      ramp_cnt_next = ramp_tick ? '0 : ramp_cnt_reg + RP_W'(1);
      if (!bump_reg) begin
         out_next = target; // R10
      end else if (ramp_tick) begin
         if ($signed(out_reg) < $signed(target)) begin
            out_next = out_reg + 12'h001; // R16
         end else if ($signed(out_reg) > $signed(target)) begin
            out_next = out_reg - 12'h001; // R16
         end
      end
      if (man_reg) begin
         vopen_next  = k_up & ~k_down; // R17
         vclose_next = k_down & ~k_up; // R17
      end else if (!run_reg) begin
         vopen_next  = (vrst_reg == oprc_pkg::VRST_OPEN); // R11
         vclose_next = (vrst_reg == oprc_pkg::VRST_CLOSE); // R11
      end else begin
         vopen_next  = pid_open_i;
         vclose_next = pid_close_i;
      end
      // Lamp flash base
      flash_next     = flash_reg;
      flash_cnt_next = flash_cnt_reg + FL_W'(1);
      if (flash_cnt_reg == FL_W'(CYC_PER_FLASH - 1)) begin
         flash_cnt_next = '0;
         flash_next     = ~flash_reg;
      end
   end

   // Outputs
   assign rdata_o             = rdata_reg;
   assign output_level_o      = out_reg;
   assign limiter_bypass_o    = ~run_reg & ~man_reg; // R10
   assign valve_open_o        = vopen_reg & config_reg[oprc_pkg::CFG_VALVE];
   assign valve_close_o       = vclose_reg & config_reg[oprc_pkg::CFG_VALVE];
   assign run_o               = run_reg;
   assign reset_led_o         = ~run_reg; // R6
   assign manual_o            = man_reg;
   assign goto_level0_o       = lvl0_reg; // R13
   assign time_count_en_o     = run_reg & ~tuning; // R14 R19
   assign tune_led_o          = tuning & flash_reg; // R19
   assign tune_mode_o         = tune_reg;
   assign tune_narrow_shown_o = ~config_reg[oprc_pkg::CFG_VALVE] &
                                ~config_reg[oprc_pkg::CFG_HEATCOOL]; // R21
   assign mode_reachable_o    = (security_reg >= oprc_pkg::SEC_LVL0) ? 8'h01 :
                                (8'hff >> security_reg); // R1 R2 R3
   assign level0_in_menu_o    = (security_reg < oprc_pkg::SEC_LVL0); // R2
   assign edit_enable_o       = (security_reg != oprc_pkg::SEC_MONITOR); // R3

   // State registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         key_s1_reg    <= 5'h00;
         key_s2_reg    <= 5'h00;
         key_d_reg     <= 5'h00;
         security_reg  <= oprc_pkg::SECURITY_RST;
         kprot_reg     <= oprc_pkg::KEY_PROT_RST;
         rst_level_reg <= oprc_pkg::LEVEL_RST;
         vrst_reg      <= oprc_pkg::VRST_HOLD;
         config_reg    <= oprc_pkg::CONFIG_RST;
         steps_reg     <= oprc_pkg::STEPS_RST;
         tune_reg      <= oprc_pkg::TUNE_CANCEL;
         rdata_reg     <= 16'h0000;
         run_reg       <= 1'b0;
         man_reg       <= 1'b0;
         lvl0_reg      <= 1'b0;
         man_level_reg <= oprc_pkg::LEVEL_RST;
         pend_reg      <= oprc_pkg::LEVEL_RST;
         pend_act_reg  <= 1'b0;
         out_reg       <= oprc_pkg::LEVEL_RST;
         bump_reg      <= 1'b0;
         vopen_reg     <= 1'b0;
         vclose_reg    <= 1'b0;
         flash_cnt_reg <= '0;
         flash_reg     <= 1'b0;
         ramp_cnt_reg  <= '0;
      end else begin
         key_s1_reg    <= {key_down_i, key_up_i, key_am_b_i, key_am_a_i, key_run_i};
         key_s2_reg    <= key_s1_reg;
         key_d_reg     <= key_s2_reg;
         security_reg  <= security_next;
         kprot_reg     <= kprot_next;
         rst_level_reg <= rst_level_next;
         vrst_reg      <= vrst_next;
         config_reg    <= config_next;
         steps_reg     <= steps_next;
         tune_reg      <= tune_next;
         rdata_reg     <= rdata_next;
         run_reg       <= run_next;
         man_reg       <= man_next;
         lvl0_reg      <= lvl0_next;
         man_level_reg <= man_level_next;
         pend_reg      <= pend_next;
         pend_act_reg  <= pend_act_next;
         out_reg       <= out_next;
         bump_reg      <= bump_next;
         vopen_reg     <= vopen_next;
         vclose_reg    <= vclose_next;
         flash_cnt_reg <= flash_cnt_next;
         flash_reg     <= flash_next;
         ramp_cnt_reg  <= ramp_cnt_next;
      end
   end
endmodule
`default_nettype wire
